// *** rtl/smc_standby_ctrl.sv ***
// Summary of operation
// R1 - Stop instruction enters deep standby, stops clocks
// R2 - Pending unmasked request at entry exits immediately
// R3 - Immediate deep exit pauses about 34 us
// R4 - Crystal source adds selected stabilisation wait
// R5 - Port latches hold values during deep standby
// R6 - Deep standby halts timers, converter, serial unit
// R7 - Low-speed interval timer keeps counting unless stopped
// R8 - Software never pairs peripheral-clock watchdog, fixed oscillator
// R9 - Only unmasked timer, detector, external requests wake
// R10 - Interval timer wakes only on low-speed clock
// R11 - Wake with enable set runs vectored servicing
// R12 - Wake with enable clear runs next instruction
// R13 - Interrupt wake pause between 17 and 67 us
// R14 - Reset in standby ends it after stabilisation
// R15 - Reset wake pauses while option byte read
// R16 - Select codes give 2^10,2^12,2^15,2^17 cycles
// R17 - Halt instruction stops only the CPU clock
// R18 - Light wake waits 12 or 4 clocks
// R19 - Wake sequence: standby, stabilise, option byte, resume
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module smc_standby_ctrl
	import smc_pkg::*;
#(
	parameter int P_PAUSE_CYC = PAUSE_CYC,
	parameter int P_OPT_CYC = OPT_CYC,
	parameter int P_STAB_C0 = STAB_C0,
	parameter int P_STAB_C1 = STAB_C1,
	parameter int P_STAB_C2 = STAB_C2,
	parameter int P_STAB_C3 = STAB_C3
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cpu_stop_exec,
	input wire logic cpu_halt_exec,
	input wire logic standby_reset_req,
	input wire smc_irq_t int_req,
	input wire smc_irq_t interrupt_mask_flag,
	input wire logic interrupt_enable_flag,
	input wire logic low_speed_osc_clk,
	output smc_ctl_t ctl,
	output smc_evt_t evt,
	output logic itmr_tick,
	output smc_state_t state
);

	typedef struct packed {
		smc_state_t st;
		logic [17:0] cnt;
		logic rst_path;
		logic [2:0] ctrl;
		logic [1:0] osc_stabilization_select;
		logic [2:0] lso_sync;
		logic lso_lvl;
		logic [ITMR_DIV_BITS-1:0] lso_div;
		logic tick;
		smc_ctl_t ctl;
		smc_evt_t evt;
		logic [7:0] rdata;
	} smc_regs_t;

	localparam smc_regs_t REGS_RESET = '{
		st: SMC_RUN,
		cnt: 18'h00000,
		rst_path: 1'b0,
		ctrl: CTRL_RESET,
		osc_stabilization_select: OSC_STABILIZATION_SELECT_RESET,
		lso_sync: 3'h0,
		lso_lvl: 1'b0,
		lso_div: '0,
		tick: 1'b0,
		ctl: '{cpu_clk_en: 1'b1, sysosc_en: 1'b1, periph_run: 1'b1,
			itmr_run: 1'b1, port_hold: 1'b0},
		evt: '0,
		rdata: 8'h00
	};

	smc_regs_t r_q;
	smc_regs_t r_d;

	logic itmr_src_ok;
	logic wake_pend;
	logic [17:0] stab_cyc;

	// Counts above the counter width would silently wrap, so cast here
	always_comb begin
		case (r_q.osc_stabilization_select)
			2'h0: stab_cyc = 18'(P_STAB_C0 - 1); // R16
			2'h1: stab_cyc = 18'(P_STAB_C1 - 1); // R16
			2'h2: stab_cyc = 18'(P_STAB_C2 - 1); // R16
			default: stab_cyc = 18'(P_STAB_C3 - 1); // R16
		endcase
	end

	// Timer only counts as a source when fed from the running slow clock
	assign itmr_src_ok = r_q.ctrl[CTRL_ITMR_LSO_BIT] &
		~r_q.ctrl[CTRL_LSO_STOP_BIT]; // R10
	assign wake_pend = (int_req.itmr & ~interrupt_mask_flag.itmr &
		itmr_src_ok) |
		(int_req.lvd & ~interrupt_mask_flag.lvd) |
		(int_req.ext & ~interrupt_mask_flag.ext); // R9

	always_comb begin
		logic lso_edge;
		logic deep;
		lso_edge = 1'b0;
		deep = 1'b0;
		r_d = r_q;
		r_d.evt = '0;
		r_d.tick = 1'b0;

		// Slow clock arrives from another domain: three flops, agree on 2 and 3
		r_d.lso_sync = {r_q.lso_sync[1:0], low_speed_osc_clk};
		if (r_q.lso_sync[2] == r_q.lso_sync[1]) begin
			r_d.lso_lvl = r_q.lso_sync[2];
		end
		lso_edge = r_d.lso_lvl & ~r_q.lso_lvl;

		// Interval timer prescaler runs through deep standby
		if (lso_edge && itmr_src_ok) begin
			r_d.lso_div = r_q.lso_div + 1'b1; // R7
			r_d.tick = &r_q.lso_div; // R7
		end

		if (reg_wr) begin
			if (reg_addr == SMC_REG_CTRL) begin
				r_d.ctrl = reg_wdata[2:0];
			end else if (reg_addr == SMC_REG_OSC_STABILIZATION_SELECT) begin
				r_d.osc_stabilization_select = reg_wdata[1:0];
			end
		end

		r_d.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == SMC_REG_CTRL) begin
				r_d.rdata = {5'h00, r_q.ctrl};
			end else if (reg_addr == SMC_REG_OSC_STABILIZATION_SELECT) begin
				r_d.rdata = {6'h00, r_q.osc_stabilization_select};
			end else if (reg_addr == SMC_REG_STAT) begin
				r_d.rdata = {3'h0, r_q.lso_lvl, r_q.rst_path, r_q.st};
			end
		end

		if (r_q.cnt != 18'h00000) begin
			r_d.cnt = r_q.cnt - 1'b1;
		end

		case (r_q.st)
			SMC_RUN: begin
				if (standby_reset_req) begin
					r_d.rst_path = 1'b1;
					r_d.cnt = 18'(P_OPT_CYC - 1);
					r_d.st = SMC_OPT;
				end else if (cpu_stop_exec) begin
					r_d.rst_path = 1'b0;
					r_d.st = SMC_STOP; // R1
				end else if (cpu_halt_exec) begin
					r_d.st = SMC_HALT; // R17
				end
			end
			SMC_HALT: begin
				if (standby_reset_req) begin
					r_d.rst_path = 1'b1;
					r_d.cnt = 18'(P_OPT_CYC - 1);
					r_d.st = SMC_OPT;
				end else if (wake_pend) begin
					r_d.cnt = interrupt_enable_flag ? HALT_WAIT_VEC - 1'b1 :
						HALT_WAIT_NXT - 1'b1; // R18
					r_d.st = SMC_HWAIT;
				end
			end
			SMC_HWAIT: begin
				if (r_q.cnt == 18'h00000) begin
					r_d.evt.resume_vector = interrupt_enable_flag;
					r_d.evt.resume_next = ~interrupt_enable_flag;
					r_d.st = SMC_RUN;
				end
			end
			SMC_STOP: begin
				// A request already pending on entry leaves at once
				if (standby_reset_req || wake_pend) begin // R2 R9
					r_d.rst_path = standby_reset_req; // R14
					if (r_q.ctrl[CTRL_XTAL_BIT]) begin
						r_d.cnt = stab_cyc; // R4
						r_d.st = SMC_STAB; // R19
					end else if (standby_reset_req) begin
						r_d.cnt = 18'(P_OPT_CYC - 1); // R15
						r_d.st = SMC_OPT; // R19
					end else begin
						r_d.cnt = 18'(P_PAUSE_CYC - 1); // R3 R13
						r_d.st = SMC_PAUSE; // R19
					end
				end
			end
			SMC_STAB: begin
				if (r_q.cnt == 18'h00000) begin
					// A reset landing on the last count must not be lost
					if (r_q.rst_path || standby_reset_req) begin
						r_d.cnt = 18'(P_OPT_CYC - 1); // R14 R15
						r_d.st = SMC_OPT;
					end else begin
						r_d.cnt = 18'(P_PAUSE_CYC - 1); // R4
						r_d.st = SMC_PAUSE;
					end
				end else if (standby_reset_req) begin
					r_d.rst_path = 1'b1; // R14
				end
			end
			SMC_PAUSE: begin
				if (standby_reset_req) begin
					r_d.rst_path = 1'b1;
					r_d.cnt = 18'(P_OPT_CYC - 1);
					r_d.st = SMC_OPT;
				end else if (r_q.cnt == 18'h00000) begin
					r_d.evt.resume_vector = interrupt_enable_flag; // R11
					r_d.evt.resume_next = ~interrupt_enable_flag; // R12
					r_d.st = SMC_RUN;
				end
			end
			SMC_OPT: begin
				if (r_q.cnt == 18'h00000) begin
					r_d.evt.reset_proc = 1'b1; // R14 R15
					r_d.rst_path = 1'b0;
					r_d.st = SMC_RUN;
				end
			end
			default: begin
				r_d.st = SMC_RUN;
			end
		endcase

		// Outputs follow the next state so they change with it, not after
		deep = (r_d.st == SMC_STOP) || (r_d.st == SMC_STAB) ||
			(r_d.st == SMC_PAUSE);
		r_d.ctl.cpu_clk_en = (r_d.st == SMC_RUN); // R1 R17
		r_d.ctl.sysosc_en = (r_d.st != SMC_STOP); // R1
		r_d.ctl.periph_run = ~deep; // R6
		r_d.ctl.itmr_run = ~deep | itmr_src_ok; // R7
		r_d.ctl.port_hold = deep; // R5
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign reg_rdata = r_q.rdata;
	assign ctl = r_q.ctl;
	assign evt = r_q.evt;
	assign itmr_tick = r_q.tick;
	assign state = r_q.st;

endmodule : smc_standby_ctrl

// *** rtl/smc_pkg.sv ***
package smc_pkg;

	localparam int CLK_MHZ = 125;

	// Register map on the plain register port
	localparam logic [7:0] SMC_REG_CTRL = 8'hf0;
	localparam logic [7:0] SMC_REG_OSC_STABILIZATION_SELECT = 8'hf4;
	localparam logic [7:0] SMC_REG_STAT = 8'hf8;

	// Control register fields
	localparam int CTRL_XTAL_BIT = 0;
	localparam int CTRL_LSO_STOP_BIT = 1;
	localparam int CTRL_ITMR_LSO_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Stabilisation select field; the cold value is undefined, take longest
	localparam logic [1:0] OSC_STABILIZATION_SELECT_RESET = 2'h3;
	localparam int STAB_C0 = 1 << 10;
	localparam int STAB_C1 = 1 << 12;
	localparam int STAB_C2 = 1 << 15;
	localparam int STAB_C3 = 1 << 17;

	// Pause after a deep standby interrupt wake (17 to 67 us, 34 typical)
	localparam int PAUSE_US = 34;
	localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
	// Option byte read after a reset wake, least time
	localparam int OPT_US = 277;
	localparam int OPT_CYC = OPT_US * CLK_MHZ;

	// Light standby wake wait in clocks
	localparam logic [17:0] HALT_WAIT_VEC = 18'h0000c;
	localparam logic [17:0] HALT_WAIT_NXT = 18'h00004;

	// Low-speed oscillator divider for the interval timer tick
	localparam int ITMR_DIV_BITS = 7;

	typedef enum logic [2:0] {
		SMC_RUN = 3'b000,
		SMC_HALT = 3'b001,
		SMC_STOP = 3'b010,
		SMC_STAB = 3'b011,
		SMC_PAUSE = 3'b100,
		SMC_OPT = 3'b101,
		SMC_HWAIT = 3'b110
	} smc_state_t;

	typedef struct packed {
		logic itmr;
		logic lvd;
		logic ext;
	} smc_irq_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic sysosc_en;
		logic periph_run;
		logic itmr_run;
		logic port_hold;
	} smc_ctl_t;

	typedef struct packed {
		logic resume_vector;
		logic resume_next;
		logic reset_proc;
	} smc_evt_t;

endpackage : smc_pkg

// *** verif/smc_standby_ctrl_properties.sv ***
`timescale 1ns/1ps
module smc_standby_ctrl_chk
	import smc_pkg::*;
#(
	parameter int P_PAUSE_CYC = PAUSE_CYC,
	parameter int P_OPT_CYC = OPT_CYC,
	parameter int P_STAB_C0 = STAB_C0,
	parameter int P_STAB_C1 = STAB_C1,
	parameter int P_STAB_C2 = STAB_C2,
	parameter int P_STAB_C3 = STAB_C3
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic cpu_stop_exec,
	input wire logic standby_reset_req,
	input wire smc_irq_t int_req,
	input wire smc_irq_t interrupt_mask_flag,
	input wire logic interrupt_enable_flag,
	input wire smc_ctl_t ctl,
	input wire smc_evt_t evt,
	input wire smc_state_t state
);
	smc_state_t prev_q;
	int cnt_q;
	int stab;
	logic [1:0] osc_stabilization_select_q;
	logic [2:0] live;
	// Cycles spent in the previous state, valid in the first cycle after
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_q <= SMC_RUN;
			cnt_q <= 0;
			osc_stabilization_select_q <= OSC_STABILIZATION_SELECT_RESET;
		end else begin
			prev_q <= state;
			cnt_q <= (state != prev_q) ? 1 : cnt_q + 1;
			if (reg_wr && reg_addr == SMC_REG_OSC_STABILIZATION_SELECT)
				osc_stabilization_select_q <= reg_wdata[1:0];
		end
	end
	always_comb begin
		live = int_req & ~interrupt_mask_flag;
		stab = osc_stabilization_select_q[1] ? (osc_stabilization_select_q[0] ? P_STAB_C3 : P_STAB_C2)
			: (osc_stabilization_select_q[0] ? P_STAB_C1 : P_STAB_C0);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_stop_entry:
		assert property (state == SMC_RUN && cpu_stop_exec &&
			!standby_reset_req |=> state == SMC_STOP) else $error("no stop");
	chk_stop_clks:
		assert property (state == SMC_STOP |-> !ctl.cpu_clk_en &&
			!ctl.sysosc_en) else $error("clock runs in stop");
	chk_port_hold:
		assert property (state inside {SMC_STOP, SMC_STAB, SMC_PAUSE} |->
			ctl.port_hold && !ctl.periph_run) else $error("no hold");
	chk_masked_held:
		assert property (state == SMC_STOP && !standby_reset_req &&
			live == 3'h0 |=> state == SMC_STOP) else $error("left stop");
	chk_wake_exit:
		assert property (state == SMC_STOP && !standby_reset_req &&
			|live[1:0] |=> state inside {SMC_STAB, SMC_PAUSE})
			else $error("no wake");
	chk_pause_len:
		assert property (state == SMC_RUN && prev_q == SMC_PAUSE |->
			cnt_q == P_PAUSE_CYC) else $error("pause length");
	chk_stab_len:
		assert property (prev_q == SMC_STAB && state != SMC_STAB |->
			cnt_q == stab) else $error("stabilise length");
	chk_reset_wake:
		assert property (state == SMC_STOP && standby_reset_req |=>
			state inside {SMC_STAB, SMC_OPT}) else $error("reset ignored");
	chk_opt_len:
		assert property (evt.reset_proc |-> prev_q == SMC_OPT &&
			cnt_q == P_OPT_CYC) else $error("option wait");
	chk_resume_kind:
		assert property (evt.resume_vector || evt.resume_next |->
			evt.resume_vector == $past(interrupt_enable_flag))
			else $error("resume kind");
	cover property (evt.resume_vector);
	cover property (evt.resume_next);
	cover property (evt.reset_proc);
endmodule : smc_standby_ctrl_chk

bind smc_standby_ctrl smc_standby_ctrl_chk #(.P_PAUSE_CYC(P_PAUSE_CYC),
	.P_OPT_CYC(P_OPT_CYC), .P_STAB_C0(P_STAB_C0), .P_STAB_C1(P_STAB_C1),
	.P_STAB_C2(P_STAB_C2), .P_STAB_C3(P_STAB_C3)) i_chk (.mclk(mclk),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.cpu_stop_exec(cpu_stop_exec), .standby_reset_req(standby_reset_req),
	.int_req(int_req), .interrupt_mask_flag(interrupt_mask_flag),
	.interrupt_enable_flag(interrupt_enable_flag), .ctl(ctl), .evt(evt),
	.state(state));

// *** verif/smc_far_model.sv ***
`timescale 1ns/1ps
module smc_far_model
	import smc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire smc_irq_t raise,
	input wire smc_irq_t clr,
	input wire smc_evt_t evt,
	output smc_irq_t int_req,
	output logic lso_clk
);
	// Flags stay set until serviced or cleared by software, as real sources
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			int_req <= '0;
		else
			int_req <= (int_req | raise) & ~clr & ~{3{evt.resume_vector}};
	end
	// No watchdog clock choice is made, so the barred pairing cannot arise
	initial begin
		lso_clk = 1'b0;
		forever #37 lso_clk = ~lso_clk;
	end
endmodule : smc_far_model

// *** verif/smc_standby_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module smc_standby_ctrl_tb_top
	import smc_pkg::*;
;
	logic mclk, rst, reg_wr, reg_rd, rd_d, cpu_stop_exec, cpu_halt_exec;
	logic standby_reset_req, interrupt_enable_flag, lso_clk, itmr_tick;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	smc_irq_t int_req, interrupt_mask_flag, raise, clr;
	smc_ctl_t ctl;
	smc_evt_t evt;
	smc_state_t state;
	int n_fail, total_checks, i, k;
	logic [7:0] rq[$];
	logic [2:0] eq[$];
	// Codes 00 and 01 keep their real cycle counts
	smc_standby_ctrl #(.P_PAUSE_CYC(20), .P_OPT_CYC(40),
		.P_STAB_C2(32), .P_STAB_C3(64)) i_smc_standby_ctrl (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_stop_exec(cpu_stop_exec), .cpu_halt_exec(cpu_halt_exec),
		.standby_reset_req(standby_reset_req), .int_req(int_req),
		.interrupt_mask_flag(interrupt_mask_flag),
		.interrupt_enable_flag(interrupt_enable_flag),
		.low_speed_osc_clk(lso_clk), .ctl(ctl), .evt(evt),
		.itmr_tick(itmr_tick), .state(state));
	smc_far_model i_smc_far_model (.mclk(mclk), .rst(rst), .raise(raise),
		.clr(clr), .evt(evt), .int_req(int_req), .lso_clk(lso_clk));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		total_checks++;
		if (e !== s) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic wait_st(smc_state_t s, int lim);
		k = 0;
		while (state !== s && k < lim) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk("state", {5'h0, s}, {5'h0, state});
		if (state !== s)
			complete_run();
	endtask : wait_st
	// Modes: 0 wake later, 1 pending at entry, 2 masked first, 3 reset
	task automatic run_stop(logic [7:0] c, logic [1:0] os, smc_irq_t src,
		logic ie, int mode);
		eq.push_back(mode == 3 ? 3'b001 : (ie ? 3'b100 : 3'b010));
		wr(SMC_REG_CTRL, c);
		wr(SMC_REG_OSC_STABILIZATION_SELECT, {6'h0, os});
		interrupt_enable_flag <= ie;
		interrupt_mask_flag <= (mode == 2) ? src : 3'h0;
		raise <= (mode == 1 || mode == 2) ? src : 3'h0;
		@(posedge mclk);
		raise <= 3'h0;
		cpu_stop_exec <= 1'b1;
		@(posedge mclk);
		cpu_stop_exec <= 1'b0;
		if (mode == 1)
			wait_st(SMC_PAUSE, 4);
		if (mode != 1) begin
			wait_st(SMC_STOP, 4);
			chk("ctl", {6'h0, c[2] & ~c[1], 1'b1}, {3'h0, ctl});
			repeat ($urandom % 8 + 2) @(posedge mclk);
			#1 chk("held", 8'h02, {5'h0, state});
			@(posedge mclk);
			interrupt_mask_flag <= 3'h0;
			raise <= (mode == 0) ? src : 3'h0;
			standby_reset_req <= (mode == 3);
			@(posedge mclk);
			raise <= 3'h0;
			standby_reset_req <= 1'b0;
		end
		wait_st(SMC_RUN, 4400);
		@(posedge mclk);
		clr <= 3'h7;
		@(posedge mclk);
		clr <= 3'h0;
		$display("stop test mode %0d done", mode);
	endtask : run_stop
	always @(posedge mclk) begin
		rd_d <= reg_rd;
		if (rd_d)
			chk("reg_rdata", rq.pop_front(), reg_rdata);
		if (!rst && evt !== 3'h0)
			chk("evt", {5'h0, eq.size() ? eq.pop_front() : 3'h0}, {5'h0, evt});
	end
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		{rst, reg_wr, reg_rd, cpu_stop_exec, cpu_halt_exec} = 5'h10;
		{standby_reset_req, interrupt_enable_flag, reg_addr, reg_wdata} = 0;
		{interrupt_mask_flag, raise, clr} = 0;
		n_fail = 0;
		total_checks = 0;
		i = $urandom(32'h9b5d72b5);
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(SMC_REG_CTRL, 8'h00);
		rd(SMC_REG_OSC_STABILIZATION_SELECT, 8'h03);
		rd(8'h10, 8'h00);
		$display("register test done");
		for (i = 0; i < 4; i++)
			run_stop(8'h01, i[1:0], 3'h1, 1'b1, 0);
		for (i = 0; i < 9; i++)
			run_stop(8'h04, 2'h0, 3'h1 << (i % 3), 1'($urandom), i % 3);
		run_stop(8'h00, 2'h0, 3'h0, 1'b0, 3);
		run_stop(8'h01, 2'h1, 3'h0, 1'b0, 3);
		for (i = 0; i < 2; i++) begin
			wr(SMC_REG_CTRL, i ? 8'h06 : 8'h04);
			k = 0;
			repeat (1500) @(posedge mclk) k += itmr_tick;
			chk("itmr_tick", 8'(!i), 8'(k > 0));
		end
		$display("tick test done");
		eq.push_back(3'b100);
		interrupt_enable_flag <= 1'b1;
		cpu_halt_exec <= 1'b1;
		@(posedge mclk);
		cpu_halt_exec <= 1'b0;
		wait_st(SMC_HALT, 4);
		chk("ctl", 8'h0e, {3'h0, ctl});
		@(posedge mclk);
		raise <= 3'h1;
		@(posedge mclk);
		raise <= 3'h0;
		wait_st(SMC_RUN, 30);
		repeat (4) @(posedge mclk);
		chk("evt left", 8'h0, 8'(eq.size()));
		$display("halt test done");
		complete_run();
	end
endmodule : smc_standby_ctrl_tb_top
